// >>> core/spac_pin_sync.sv
// Pin synchroniser and edge finder for the serial control lines
`timescale 1ns/1ps
module spac_pin_sync
    import spac_pkg::*;
(
    // Clocking
    input  wire logic core_clk,
    input  wire logic rst_b,
    input  wire logic clk_en,
    // Raw pins
    input  wire logic sel_n,
    input  wire logic shift_clk,
    input  wire logic serial_in,
    input  wire logic latch_strobe,
    // Synchronised side
    spac_pins_if.src  pins
);
    // ------------------------------------------------------------------
    // Two-stage synchronisers; first stage feeds only the second
    // ------------------------------------------------------------------
    logic [3:0] meta_r;   // First stage
    logic [3:0] sync_r;   // Second stage
    logic [1:0] prev_r;   // Previous clk and latch for edge finding

    // Synchronise all four pins; idle levels are high for select and strobes
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            meta_r <= 4'hF;
            sync_r <= 4'hF;
        end else if (clk_en) begin
            meta_r <= {latch_strobe, serial_in, shift_clk, sel_n};
            sync_r <= meta_r;
        end
    end

    // Remember last synchronised levels of clock and latch
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            prev_r <= 2'h3;
        end else if (clk_en) begin
            prev_r <= {sync_r[3], sync_r[1]};
        end
    end

    assign pins.sel_n_s    = sync_r[0];
    assign pins.data_s     = sync_r[2];
    // Edge pulses only count while the clock enable lets state move
    assign pins.clk_fall   = clk_en & prev_r[0] & ~sync_r[1];
    assign pins.latch_fall = clk_en & prev_r[1] & ~sync_r[3];
endmodule // spac_pin_sync

// >>> core/spac_pins_if.sv
// Interface carrying synchronised pin edges between the sampler and the core
`timescale 1ns/1ps
interface spac_pins_if;
    logic sel_n_s;      // Synchronised active-low select
    logic data_s;       // Synchronised serial data
    logic clk_fall;     // One-cycle pulse on shift clock falling edge
    logic latch_fall;   // One-cycle pulse on latch strobe falling edge
    modport src (output sel_n_s, data_s, clk_fall, latch_fall);
    modport dst (input  sel_n_s, data_s, clk_fall, latch_fall);
endinterface // spac_pins_if

// >>> core/spac_pkg.sv
// Package with constants for the serial phase and attenuation control block
package spac_pkg;
    // ------------------------------------------------------------------
    // Word layout
    // ------------------------------------------------------------------
    localparam int WORD_BITS       = 24;     // Serial word length
    localparam int FIELD_BITS      = 6;      // Width of each setting field
    localparam int CH2_PHASE_LSB   = 0;      // Bits 1..6
    localparam int CH2_ATTEN_LSB   = 6;      // Bits 7..12
    localparam int CH1_ATTEN_LSB   = 12;     // Bits 13..18
    localparam int CH1_PHASE_LSB   = 18;     // Bits 19..24
    localparam logic [23:0] HOLD_RESET = 24'h000000; // All-zero state
    // ------------------------------------------------------------------
    // Counting
    // ------------------------------------------------------------------
    localparam int CNT_BITS        = 5;      // Holds 0..24
    localparam logic [4:0] CNT_FULL = 5'h18; // 24 clocks seen
    localparam int SYNC_STAGES     = 2;      // Pin synchroniser depth
endpackage

// >>> core/spac_top.sv
// Serial front end for a dual-channel phase shifter and attenuator
`timescale 1ns/1ps
// What this block does
// - Accepts serial input only while select low
// - Shifts data in on each shift-clock fall
// - Shift register holds a 24-bit word
// - Latch fall after 24 clocks loads holding register
// - Select high blocks the shift clock
// - Deselected, shift register holds, but a latch fall still copies it to the holding register
// - Each channel has 6-bit phase setting
// - Each channel has 6-bit attenuation setting
// - One word; all-zero means zero everywhere
module spac_top
    import spac_pkg::*;
#(
    parameter int WORD_W = WORD_BITS   // Serial word length
)(
    // Clocking
    input  wire logic             core_clk,
    input  wire logic             rst_b,
    input  wire logic             clk_en,
    // Serial control pins
    input  wire logic             sel_n,
    input  wire logic             shift_clk,
    input  wire logic             serial_in,
    input  wire logic             latch_strobe,
    // Settings
    output logic [FIELD_BITS-1:0] ch1_phase,
    output logic [FIELD_BITS-1:0] ch1_atten,
    output logic [FIELD_BITS-1:0] ch2_phase,
    output logic [FIELD_BITS-1:0] ch2_atten,
    // Status
    output logic                  word_loaded,
    output logic                  latch_seen
);
    // ------------------------------------------------------------------
    // Pin sampling
    // ------------------------------------------------------------------
    // The link clock is only sampled, never used as a clock, so the whole
    // block stays in one domain; pin pulses under one core period may be lost
    spac_pins_if pins ();   // Synchronised pins and edges

    spac_pin_sync u_sync (
        .core_clk     (core_clk),
        .rst_b        (rst_b),
        .clk_en       (clk_en),
        .sel_n        (sel_n),
        .shift_clk    (shift_clk),
        .serial_in    (serial_in),
        .latch_strobe (latch_strobe),
        .pins         (pins)
    );

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic [WORD_W-1:0]   shift_r;   // Incoming word, newest bit at index 0
    logic [CNT_BITS-1:0] count_r;   // Clocks shifted since last latch
    logic [WORD_W-1:0]   hold_r;    // Latched word driving the settings
    logic                loaded_r;  // A full word has been latched
    logic                seen_r;    // Any latch edge has arrived
    logic                shift_go;  // Shift this cycle
    logic                load_go;   // Latch this cycle

    // Trade-off: edges are found on synchronised levels, which costs three
    // core clocks of latency but keeps every flop on core_clk
    // Shift only on a clock fall while selected; select high gates it
    assign shift_go = pins.clk_fall & ~pins.sel_n_s;
    // Latch needs a complete word; a short burst is ignored
    assign load_go  = pins.latch_fall && (count_r >= CNT_FULL);

    // ------------------------------------------------------------------
    // Shift register
    // ------------------------------------------------------------------
    // Bit 24 arrives first and moves up until it sits at the top
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            shift_r <= '0;
        end else if (shift_go) begin
            shift_r <= {shift_r[WORD_W-2:0], pins.data_s};
        end
    end

    // ------------------------------------------------------------------
    // Clock counter
    // ------------------------------------------------------------------
    // Clearing on every latch edge, qualified or not, means a short word
    // can never be topped up to a full one by a later burst
    // Saturates at full so extra clocks still keep the last 24 bits
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            count_r <= '0;
        end else if (pins.latch_fall) begin
            count_r <= '0;
        end else if (shift_go && count_r < CNT_FULL) begin
            count_r <= count_r + 5'h01;
        end
    end

    // ------------------------------------------------------------------
    // Holding register
    // ------------------------------------------------------------------
    // Power-up content of the holding flops is not defined at the pins; zero
    // is chosen so that an unloaded block asks for no shift and no loss
    // Changes only on a qualified latch; otherwise retains the word
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            hold_r <= HOLD_RESET;
        end else if (load_go) begin
            hold_r <= shift_r;
        end
    end

    // ------------------------------------------------------------------
    // Status flags
    // ------------------------------------------------------------------
    // Both flags are sticky and only reset clears them, so no
    // set-versus-clear race has to be settled here
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            loaded_r <= 1'b0;
            seen_r   <= 1'b0;
        end else begin
            if (load_go) begin
                loaded_r <= 1'b1;
            end
            if (pins.latch_fall) begin
                seen_r <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Outputs, straight from the holding flops
    // ------------------------------------------------------------------
    // Register index k holds word bit k+1; fields run small weight upward
    assign ch2_phase   = hold_r[CH2_PHASE_LSB +: FIELD_BITS];
    assign ch2_atten   = hold_r[CH2_ATTEN_LSB +: FIELD_BITS];
    assign ch1_atten   = hold_r[CH1_ATTEN_LSB +: FIELD_BITS];
    assign ch1_phase   = hold_r[CH1_PHASE_LSB +: FIELD_BITS];
    assign word_loaded = loaded_r;
    assign latch_seen  = seen_r;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    sequence s_full_latch;
        (count_r == CNT_FULL) ##0 pins.latch_fall;
    endsequence

    chk_sel_blocks_shift: assert property (@(posedge core_clk) disable iff (!rst_b)
        pins.sel_n_s |=> $stable(shift_r))
        else $error("shift register moved while deselected");

    chk_shift_on_fall: assert property (@(posedge core_clk) disable iff (!rst_b)
        shift_go |=> shift_r[0] == $past(pins.data_s))
        else $error("data bit not shifted in on clock fall");

    chk_shift_order: assert property (@(posedge core_clk) disable iff (!rst_b)
        shift_go |=> shift_r[WORD_W-1:1] == $past(shift_r[WORD_W-2:0]))
        else $error("shift register did not move up by one");

    chk_latch_load: assert property (@(posedge core_clk) disable iff (!rst_b)
        s_full_latch |=> hold_r == $past(shift_r) && word_loaded)
        else $error("full word not latched on strobe fall");

    chk_short_ignored: assert property (@(posedge core_clk) disable iff (!rst_b)
        pins.latch_fall && count_r < CNT_FULL |=> $stable(hold_r))
        else $error("short word was latched");

    chk_hold_stable: assert property (@(posedge core_clk) disable iff (!rst_b)
        !pins.latch_fall |=> $stable(hold_r))
        else $error("holding register changed without latch");

    chk_select_gate: assert property (@(posedge core_clk) disable iff (!rst_b)
        pins.clk_fall && !pins.sel_n_s |=> count_r != 5'h00)
        else $error("clock fall while selected not counted");

    chk_fields_map: assert property (@(posedge core_clk) disable iff (!rst_b)
        {ch1_phase, ch1_atten, ch2_atten, ch2_phase} == hold_r)
        else $error("setting fields misplaced in word");

    chk_zero_reset: assert property (@(posedge core_clk)
        $rose(rst_b) |-> hold_r == HOLD_RESET && !word_loaded)
        else $error("holding register not zero after reset");

    // ------------------------------------------------------------------
    // Checks on counting, flags and clock enable
    // ------------------------------------------------------------------
    // A counted shift is a selected clock fall below a full count with no latch edge beside it
    sequence s_counted_shift;
        shift_go && !pins.latch_fall && (count_r < CNT_FULL);
    endsequence

    // Each counted shift moves the counter by exactly one
    chk_count_step: assert property (@(posedge core_clk) disable iff (!rst_b)
        s_counted_shift |=> count_r == $past(count_r) + 5'h01)
        else $error("shift counter did not advance by one");

    // The counter saturates; a long burst must not wrap it back below full
    chk_count_limit: assert property (@(posedge core_clk) disable iff (!rst_b)
        count_r <= CNT_FULL)
        else $error("shift counter passed a full word");

    // Any latch edge restarts the word and is remembered
    chk_latch_clears: assert property (@(posedge core_clk) disable iff (!rst_b)
        pins.latch_fall |=> count_r == 5'h00 && latch_seen)
        else $error("latch edge did not restart the word count");

    // Once a word is in, the flag stays until the next reset
    chk_loaded_sticky: assert property (@(posedge core_clk) disable iff (!rst_b)
        word_loaded |=> word_loaded)
        else $error("loaded flag dropped without reset");

    // With the enable low nothing may move, whatever the pins do
    chk_clken_freeze: assert property (@(posedge core_clk) disable iff (!rst_b)
        !clk_en |=> $stable(shift_r) && $stable(count_r) && $stable(hold_r))
        else $error("state moved while clock enable was low");
endmodule // spac_top

// >>> testbench/spac_ctrl_model.sv
// Controller model driving the serial control pins of the front end
`timescale 1ns/1ps
module spac_ctrl_model (
    // Timing reference
    input  wire logic core_clk,
    // Serial control pins
    output logic      sel_n,
    output logic      shift_clk,
    output logic      serial_in,
    output logic      latch_strobe
);
    // ------------------------------------------------------------------
    // Idle levels
    // ------------------------------------------------------------------
    // All strobes high, so reset release sees no false falling edge
    initial begin
        sel_n        = 1'h1;
        shift_clk    = 1'h1;
        serial_in    = 1'h0;
        latch_strobe = 1'h1;
    end
    // Half of the 80 ns link period, launched just after a core edge
    task automatic half();
        repeat (8) @(posedge core_clk);
        #1;
    endtask
    // ------------------------------------------------------------------
    // Frame tasks
    // ------------------------------------------------------------------
    // Sends n bits, highest first; the clock only moves inside a frame
    task automatic send(input logic [31:0] w, input int n, input logic sel);
        sel_n = sel;
        for (int k = n - 1; k >= 0; k--) begin
            serial_in = w[k];
            half();
            shift_clk = 1'h0;
            half();
            shift_clk = 1'h1;
        end
        half();
        sel_n     = 1'h1;
        // Released data line must not keep showing the last bit
        serial_in = ~serial_in;
    endtask
    // Latch pulse, a whole half period clear of any clock fall
    task automatic latch();
        latch_strobe = 1'h0;
        half();
        latch_strobe = 1'h1;
        half();
    endtask
endmodule // spac_ctrl_model

// >>> testbench/testbench.sv
// Self-checking bench for the serial phase and attenuation front end
`timescale 1ns/1ps
module testbench;
    import spac_pkg::*;
    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    logic                  core_clk, rst_b, clk_en;
    logic                  sel_n, shift_clk, serial_in, latch_strobe;
    logic [FIELD_BITS-1:0] ch1_phase, ch1_atten, ch2_phase, ch2_atten;
    logic                  word_loaded, latch_seen;
    logic [23:0]           exp_q[$];   // Expected settings, oldest first
    logic [23:0]           prev_r;     // Settings seen one edge ago
    logic [23:0]           w;          // Scratch word
    int                    n_mismatch, n_compared, seed;
    wire  logic [23:0]     cur = {ch1_phase, ch1_atten, ch2_atten, ch2_phase};

    spac_top uut (.core_clk(core_clk), .rst_b(rst_b), .clk_en(clk_en), .sel_n(sel_n),
        .shift_clk(shift_clk), .serial_in(serial_in), .latch_strobe(latch_strobe),
        .ch1_phase(ch1_phase), .ch1_atten(ch1_atten), .ch2_phase(ch2_phase),
        .ch2_atten(ch2_atten), .word_loaded(word_loaded), .latch_seen(latch_seen));
    spac_ctrl_model ctl (.core_clk(core_clk), .sel_n(sel_n), .shift_clk(shift_clk),
        .serial_in(serial_in), .latch_strobe(latch_strobe));

    // 200 MHz core clock
    initial begin
        core_clk = 1'h0;
        forever #2.5 core_clk = ~core_clk;
    end
    // ------------------------------------------------------------------
    // Checking
    // ------------------------------------------------------------------
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("Compared %0d, mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Any settings change takes the oldest note; a change with none noted is wrong
    always @(posedge core_clk) begin
        if (rst_b === 1'h1 && cur !== prev_r) begin
            if (exp_q.size() == 0) begin
                check(cur, prev_r);
            end else begin
                check(cur, exp_q.pop_front());
                check({23'h0, word_loaded}, 24'h1);
            end
        end
        prev_r <= cur;
    end
    // Bounded wait until every noted result has shown up
    task automatic drain();
        for (int t = 0; t < 40 && exp_q.size() != 0; t++) begin
            @(posedge core_clk);
        end
        if (exp_q.size() != 0) begin
            n_mismatch++;
            report_and_stop();
        end
    endtask
    // Full frame plus latch; the low 24 bits sent are the ones expected
    task automatic put(input logic [31:0] v, input int n);
        @(posedge core_clk);
        #1;
        exp_q.push_back(v[23:0]);
        ctl.send(v, n, 1'h0);
        ctl.latch();
        drain();
    endtask
    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        seed       = 63;
        n_mismatch = 0;
        n_compared = 0;
        clk_en     = 1'h1;
        rst_b      = 1'h0;
        prev_r     = 24'h0;
        repeat (10) @(posedge core_clk);
        #1;
        rst_b = 1'h1;
        check(cur, HOLD_RESET);
        check({23'h0, latch_seen}, 24'h0);
        // Walking one lands every bit in its own field position
        for (int i = 0; i < 24; i++) begin
            put(32'h1 << i, 24);
        end
        put(32'h0, 24);
        // Random words behind four surplus leading bits: last 24 kept
        for (int i = 0; i < 6; i++) begin
            w = 24'($random(seed));
            w = (w === cur) ? ~w : w;
            put({8'h5A, w}, 28);
        end
        // A 23-bit frame must not reach the outputs on latch
        ctl.send({8'h00, ~cur}, 23, 1'h0);
        ctl.latch();
        check({23'h0, latch_seen}, 24'h1);
        // Bits sent while deselected must not disturb the shifted word
        w = ~cur;
        exp_q.push_back(w);
        ctl.send({8'h00, w}, 24, 1'h0);
        ctl.half();
        ctl.send({8'h00, ~w}, 24, 1'h1);
        ctl.latch();
        drain();
        // Enable held low: a whole frame and latch must leave no trace
        clk_en = 1'h0;
        w      = cur;
        ctl.send({8'h00, ~w}, 24, 1'h0);
        ctl.latch();
        clk_en = 1'h1;
        repeat (8) @(posedge core_clk);
        #1;
        check(cur, w);
        // Reset in mid-run: settings and both flags fall back to zero
        rst_b = 1'h0;
        repeat (3) @(posedge core_clk);
        #1;
        rst_b = 1'h1;
        check(cur, HOLD_RESET);
        check({22'h0, word_loaded, latch_seen}, 24'h0);
        // The block takes a full word again straight after the release
        w = ~cur;
        put({8'h00, w}, 24);
        repeat (50) @(posedge core_clk);
        report_and_stop();
    end
endmodule // testbench
